//--- hdl/aait_pkg.sv
// Constants for the agent and function index table register bank
package aait_pkg;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int AGT_MAX = 32;
  localparam int FN_MAX = 32;
  localparam int CW = 6;
  localparam logic [AW-1:0] OFF_AGT_PTR = 12'h004;
  localparam logic [AW-1:0] OFF_FN_PTR = 12'h008;
  localparam logic [AW-1:0] OFF_BND_PTR = 12'h00C;
  localparam logic [AW-1:0] OFF_CTRL = 12'h010;
  localparam logic [AW-1:0] OFF_STAT = 12'h014;
  localparam logic [AW-1:0] OFF_AGT_TBL = 12'h020;
  localparam logic [AW-1:0] OFF_FN_TBL = 12'h0A0;
  localparam logic [AW-1:0] OFF_BND_TBL = 12'h120;
  localparam logic [AW-1:0] DVSEC_BYTES = 12'h200;
  localparam int PTR_SIZE_LSB = 0;
  localparam int PTR_RSV_LSB = 12;
  localparam int PTR_OFF_LSB = 20;
  localparam int AGT_PORT_LSB = 8;
  localparam int AGT_FN_LSB = 12;
  localparam int AGT_CAP_LSB = 20;
  localparam int FN_PORT_LSB = 20;
  localparam int FN_NUM_LSB = 24;
  localparam int AGT_KW = 24;
  localparam int FN_KW = 12;
  localparam int CTRL_FN_EN = 0;
  localparam logic CTRL_FN_EN_RST = 1'b1;
  localparam int STAT_AGT_CNT_LSB = 0;
  localparam int STAT_FN_CNT_LSB = 8;
  localparam int STAT_REJECT = 16;
  localparam int STAT_AGT_OK = 17;
endpackage : aait_pkg

//--- hdl/aait_match_if.sv
// Interface carrying stored keys and a candidate key to the duplicate matcher
`timescale 1ns/1ps
interface aait_match_if #(
  parameter int N = 32,
  parameter int KW = 24
);
  logic [N*KW-1:0] keys;
  logic [N-1:0] live;
  logic [KW-1:0] cand;
  logic hit;
  modport owner (output keys, output live, output cand, input hit);
  modport matcher (input keys, input live, input cand, output hit);
endinterface : aait_match_if

//--- hdl/aait_dup_match.sv
// Compares a candidate key against every live stored key
`timescale 1ns/1ps
module aait_dup_match #(
  parameter int N = 32,
  parameter int KW = 24
) (
  aait_match_if.matcher m
);
  logic [N-1:0] eq;

  // One comparator per stored entry
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cmp
      assign eq[g] = m.live[g] && (m.keys[g*KW +: KW] == m.cand);
    end
  endgenerate

  assign m.hit = |eq;
endmodule : aait_dup_match

//--- hdl/aait_index_tables.sv
// Read-only agent and function index tables with their pointer registers
`timescale 1ns/1ps
module aait_index_tables
  import aait_pkg::*;
#(
  parameter int AGT_N = AGT_MAX,
  parameter int FN_N = FN_MAX
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic tbl_load,
  input wire logic tbl_sel,
  input wire logic tbl_clear,
  input wire logic [3:0] tbl_port,
  input wire logic [7:0] tbl_func,
  input wire logic [11:0] tbl_capoff,
  output logic tbl_reject,
  output logic [CW-1:0] agent_count,
  output logic [CW-1:0] function_count
);
  // Address lies inside a table of cnt dword entries starting at base
  function automatic logic in_tbl(input logic [AW-1:0] a, input logic [AW-1:0] base,
                                  input logic [CW-1:0] cnt);
    logic [AW-1:0] lim;
    lim = base + AW'({cnt, 2'b00});
    return (a[1:0] == 2'b00) && (a >= base) && (a < lim);
  endfunction : in_tbl

  // Entry position of an address within a table
  function automatic logic [4:0] tbl_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
    logic [AW-1:0] d;
    d = a - base;
    return d[6:2];
  endfunction : tbl_idx

  // Pointer word: offset, zero reserved bits, size in dwords
  function automatic logic [DW-1:0] ptr_word(input logic [AW-1:0] off,
                                             input logic [CW-1:0] cnt);
    logic [DW-1:0] w;
    w = '0;
    w[PTR_OFF_LSB +: 12] = {off[AW-1:2], 2'b00};
    w[PTR_SIZE_LSB +: 12] = 12'(cnt);
    return w;
  endfunction : ptr_word

  logic [AGT_KW-1:0] agt_mem [AGT_N];
  logic [FN_KW-1:0] fn_mem [FN_N];
  logic [CW-1:0] agt_cnt_q;
  logic [CW-1:0] agt_cnt_d;
  logic [CW-1:0] fn_cnt_q;
  logic [CW-1:0] fn_cnt_d;
  logic fn_en_q;
  logic fn_en_d;
  logic reject_q;
  logic reject_d;
  logic tbl_reject_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  aait_match_if #(.N(AGT_N), .KW(AGT_KW)) agt_m ();
  aait_match_if #(.N(FN_N), .KW(FN_KW)) fn_m ();

  aait_dup_match #(.N(AGT_N), .KW(AGT_KW)) u_agt_match (.m(agt_m.matcher));
  aait_dup_match #(.N(FN_N), .KW(FN_KW)) u_fn_match (.m(fn_m.matcher));

  // Present stored keys and the candidate to the matchers
  always_comb begin
    for (int i = 0; i < AGT_N; i++) begin
      agt_m.keys[i*AGT_KW +: AGT_KW] = agt_mem[i];
      agt_m.live[i] = (CW'(i) < agt_cnt_q);
    end
    for (int i = 0; i < FN_N; i++) begin
      fn_m.keys[i*FN_KW +: FN_KW] = fn_mem[i];
      fn_m.live[i] = (CW'(i) < fn_cnt_q);
    end
  end
  assign agt_m.cand = {tbl_capoff, tbl_func, tbl_port};
  assign fn_m.cand = {tbl_func, tbl_port};

  // Load decisions
  wire agt_full = (agt_cnt_q >= CW'(AGT_N));
  wire fn_full = (fn_cnt_q >= CW'(FN_N));
  wire agt_load = tbl_load && !tbl_clear && !tbl_sel;
  wire fn_load = tbl_load && !tbl_clear && tbl_sel;
  wire agt_ok = agt_load && !agt_full && !agt_m.hit;
  wire fn_ok = fn_load && !fn_full && !fn_m.hit;
  wire load_bad = (agt_load && !agt_ok) || (fn_load && !fn_ok);

  assign agt_cnt_d = tbl_clear ? '0 : agt_cnt_q + CW'(agt_ok);
  assign fn_cnt_d = tbl_clear ? '0 : fn_cnt_q + CW'(fn_ok);

  // Register decode
  wire wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
  wire wr_stat = reg_wr && (reg_addr == OFF_STAT);
  wire clr_reject = wr_stat && reg_wdata[STAT_REJECT];
  assign fn_en_d = wr_ctrl ? reg_wdata[CTRL_FN_EN] : fn_en_q;
  assign reject_d = load_bad || (reject_q && !clr_reject);

  // Pointer words, entries and status
  wire fn_absent = !fn_en_q || (fn_cnt_q == '0);
  wire [DW-1:0] agt_ptr = ptr_word(OFF_AGT_TBL, agt_cnt_q);
  wire [DW-1:0] fn_ptr = fn_absent ? '0 : ptr_word(OFF_FN_TBL, fn_cnt_q);
  wire [DW-1:0] bnd_ptr = ptr_word(OFF_BND_TBL, fn_cnt_q);
  wire hit_agt = in_tbl(reg_addr, OFF_AGT_TBL, agt_cnt_q);
  wire hit_fn = !fn_absent && in_tbl(reg_addr, OFF_FN_TBL, fn_cnt_q);
  wire [AGT_KW-1:0] agt_ent = agt_mem[tbl_idx(reg_addr, OFF_AGT_TBL)];
  wire [FN_KW-1:0] fn_ent = fn_mem[tbl_idx(reg_addr, OFF_FN_TBL)];
  wire [DW-1:0] agt_word = {agt_ent, 8'h00};
  wire [DW-1:0] fn_word = {fn_ent, 20'h00000};
  wire [DW-1:0] stat_word = {14'h0000, (agt_cnt_q != '0), reject_q,
                             2'b00, fn_cnt_q, 2'b00, agt_cnt_q};
  wire [DW-1:0] ctrl_word = {31'h00000000, fn_en_q};

  // Read mux; unmapped or empty locations read zero
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      OFF_AGT_PTR: rdata_d = agt_ptr;
      OFF_FN_PTR: rdata_d = fn_ptr;
      OFF_BND_PTR: rdata_d = bnd_ptr;
      OFF_CTRL: rdata_d = ctrl_word;
      OFF_STAT: rdata_d = stat_word;
      default: begin
        if (hit_agt) begin
          rdata_d = agt_word;
        end else if (hit_fn) begin
          rdata_d = fn_word;
        end
      end
    endcase
  end

  // Control and status state; table fields ignore software writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      agt_cnt_q <= '0;
      fn_cnt_q <= '0;
      fn_en_q <= CTRL_FN_EN_RST;
      reject_q <= 1'b0;
      tbl_reject_q <= 1'b0;
      rdata_q <= '0;
    end else if (ce) begin
      agt_cnt_q <= agt_cnt_d;
      fn_cnt_q <= fn_cnt_d;
      fn_en_q <= fn_en_d;
      reject_q <= reject_d;
      tbl_reject_q <= load_bad;
      rdata_q <= reg_rd ? rdata_d : '0;
    end
  end

  // Entry storage appends at the current count
  always_ff @(posedge clk_sys) begin
    if (ce && agt_ok) begin
      agt_mem[agt_cnt_q[4:0]] <= agt_m.cand;
    end
    if (ce && fn_ok) begin
      fn_mem[fn_cnt_q[4:0]] <= fn_m.cand;
    end
  end

  assign reg_rdata = rdata_q;
  assign tbl_reject = tbl_reject_q;
  assign agent_count = agt_cnt_q;
  assign function_count = fn_cnt_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence rd_at(logic [AW-1:0] a);
    ce && reg_rd && (reg_addr == a);
  endsequence

  sequence agt_load_seq;
    ce && agt_load && !agt_full && !agt_m.hit;
  endsequence

  sequence fn_load_seq;
    ce && fn_load && !fn_full && !fn_m.hit;
  endsequence

  sequence agt_dup_seq;
    ce && agt_load && agt_m.hit && !agt_full;
  endsequence

  sequence fn_dup_seq;
    ce && fn_load && fn_m.hit && !fn_full;
  endsequence

  ptr_rsv_zero_a: assert property (ce && reg_rd
    && (reg_addr == OFF_BND_PTR || reg_addr == OFF_FN_PTR)
    |=> reg_rdata[19:12] == 8'h00) else $error("pointer reserved bits set");
  fn_off_align_a: assert property (rd_at(OFF_FN_PTR)
    |=> reg_rdata[21:20] == 2'b00) else $error("function offset unaligned");
  fn_null_ptr_a: assert property (rd_at(OFF_FN_PTR) ##0 fn_absent
    |=> reg_rdata == '0) else $error("absent table not null");
  bnd_ptr_val_a: assert property (rd_at(OFF_BND_PTR)
    |=> reg_rdata == {OFF_BND_TBL, 8'h00, 12'($past(fn_cnt_q))})
    else $error("binding pointer wrong");
  ptr_fit_a: assert property (OFF_FN_TBL + AW'({fn_cnt_q, 2'b00}) <= DVSEC_BYTES
    && OFF_BND_TBL + AW'({fn_cnt_q, 2'b00}) <= DVSEC_BYTES
    && OFF_AGT_TBL + AW'({agt_cnt_q, 2'b00}) <= DVSEC_BYTES)
    else $error("table runs past structure");
  agt_max_a: assert property (agt_cnt_q <= CW'(AGT_N))
    else $error("agent count above limit");
  agt_dup_a: assert property (agt_dup_seq
    |=> $stable(agt_cnt_q) ##0 tbl_reject) else $error("duplicate agent taken");
  agt_pos_a: assert property (agt_load_seq
    |=> agt_cnt_q == $past(agt_cnt_q) + 1'b1
    ##0 agt_mem[5'($past(agt_cnt_q))] == $past(agt_m.cand))
    else $error("agent entry not at position");
  fn_dup_a: assert property (fn_dup_seq
    |=> $stable(fn_cnt_q) ##0 tbl_reject) else $error("duplicate function taken");
  fn_pos_a: assert property (fn_load_seq
    |=> fn_cnt_q == $past(fn_cnt_q) + 1'b1
    ##0 fn_mem[5'($past(fn_cnt_q))] == $past(fn_m.cand))
    else $error("function entry not at position");
  fn_max_a: assert property (fn_cnt_q <= CW'(FN_N))
    else $error("function count above limit");
  clr_empty_a: assert property (ce && tbl_clear
    |=> agt_cnt_q == '0 && fn_cnt_q == '0) else $error("clear left entries");
  rd_idle_a: assert property (ce && !reg_rd
    |=> reg_rdata == '0) else $error("read data not idle");
  ce_freeze_a: assert property (!ce
    |=> $stable(agt_cnt_q) && $stable(fn_cnt_q) && $stable(reg_rdata))
    else $error("state moved without enable");
  agt_rsv_a: assert property (ce && reg_rd && hit_agt && reg_addr >= OFF_AGT_TBL
    |=> reg_rdata[7:0] == 8'h00) else $error("agent reserved bits set");
  fn_rsv_a: assert property (ce && reg_rd && hit_fn && !hit_agt
    |=> reg_rdata[19:0] == 20'h00000) else $error("function reserved bits set");
  wr_no_eff_a: assert property (ce && reg_wr && reg_addr <= OFF_BND_PTR && !tbl_load
    && !tbl_clear |=> $stable(agt_ptr) && $stable(fn_ptr))
    else $error("write changed pointer");
endmodule : aait_index_tables

//--- sim/tb_accel_agent_index_tables.sv
// Self-checking bench for the agent and function index table register bank
`timescale 1ns/1ps
module tb_accel_agent_index_tables;
  import aait_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tbl_load = 1'b0;
  logic tbl_sel = 1'b0;
  logic tbl_clear = 1'b0;
  logic [3:0] tbl_port = '0;
  logic [7:0] tbl_func = '0;
  logic [11:0] tbl_capoff = '0;
  logic [DW-1:0] reg_rdata;
  logic tbl_reject;
  logic [CW-1:0] agent_count;
  logic [CW-1:0] function_count;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] agt_q[$];
  logic [31:0] fn_q[$];
  logic fn_en = 1'b1;
  logic sticky = 1'b0;
  logic [AW-1:0] ro_addr [5] = '{OFF_AGT_PTR, OFF_FN_PTR, OFF_BND_PTR, OFF_AGT_TBL,
    OFF_FN_TBL};

  always #5 clk_sys = ~clk_sys;

  aait_index_tables uut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tbl_load(tbl_load), .tbl_sel(tbl_sel), .tbl_clear(tbl_clear), .tbl_port(tbl_port),
    .tbl_func(tbl_func), .tbl_capoff(tbl_capoff), .tbl_reject(tbl_reject),
    .agent_count(agent_count), .function_count(function_count));

  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, reg_rdata);
  endtask : rd

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  function automatic logic [31:0] ptr(input logic [11:0] off, input int n);
    return {off, 8'h00, 12'(n)};
  endfunction : ptr

  task automatic check_regs;
    logic fn_live;
    fn_live = fn_en && fn_q.size() != 0;
    rd(OFF_AGT_PTR, ptr(OFF_AGT_TBL, agt_q.size()));
    rd(OFF_FN_PTR, fn_live ? ptr(OFF_FN_TBL, fn_q.size()) : 32'h0000_0000);
    rd(OFF_BND_PTR, ptr(OFF_BND_TBL, fn_q.size()));
    rd(OFF_STAT, {14'h0, agt_q.size() != 0, sticky, 2'b00, 6'(fn_q.size()), 2'b00,
      6'(agt_q.size())});
    for (int i = 0; i < AGT_MAX; i++) begin
      rd(OFF_AGT_TBL + 12'(4 * i), i < agt_q.size() ? agt_q[i] : 32'h0000_0000);
    end
    for (int i = 0; i < FN_MAX; i++) begin
      rd(OFF_FN_TBL + 12'(4 * i), fn_live && i < fn_q.size() ? fn_q[i] : 32'h0);
    end
  endtask : check_regs

  task automatic ld(input logic sel, input logic [3:0] p, input logic [7:0] f,
      input logic [11:0] c);
    logic [31:0] w;
    logic rej;
    w = sel ? {f, p, 20'h00000} : {c, f, p, 8'h00};
    rej = sel ? fn_q.size() >= FN_MAX : agt_q.size() >= AGT_MAX;
    if (sel) foreach (fn_q[i]) rej |= fn_q[i] == w;
    else foreach (agt_q[i]) rej |= agt_q[i] == w;
    @(posedge clk_sys);
    tbl_load <= 1'b1;
    tbl_sel <= sel;
    tbl_port <= p;
    tbl_func <= f;
    tbl_capoff <= c;
    @(posedge clk_sys);
    tbl_load <= 1'b0;
    if (rej) sticky = 1'b1;
    else if (sel) fn_q.push_back(w);
    else agt_q.push_back(w);
    #1;
    chk("reject", 32'(rej), 32'(tbl_reject));
    chk("agent count", 32'(agt_q.size()), 32'(agent_count));
    chk("function count", 32'(fn_q.size()), 32'(function_count));
  endtask : ld

  initial begin
    void'($urandom(75));
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    check_regs;
    for (int i = 0; i < 5; i++) ld(1'b0, 4'($urandom), 8'($urandom), 12'($urandom));
    ld(1'b0, agt_q[2][11:8], agt_q[2][19:12], agt_q[2][31:20]);
    ld(1'b0, agt_q[2][11:8], agt_q[2][19:12], agt_q[2][31:20] ^ 12'h004);
    for (int i = 0; i < 6; i++) ld(1'b1, 4'($urandom), 8'($urandom), 12'($urandom));
    ld(1'b1, fn_q[1][23:20], fn_q[1][31:24], 12'($urandom));
    ld(1'b1, 4'hF, 8'hFF, 12'h000);
    rd(OFF_FN_PTR, ptr(OFF_FN_TBL, fn_q.size()));
    @(posedge clk_sys);
    #1;
    chk("rdata idle", 32'h0000_0000, reg_rdata);
    while (agt_q.size() < AGT_MAX) ld(1'b0, 4'($urandom), 8'($urandom), 12'($urandom));
    ld(1'b0, 4'h0, 8'h00, 12'hFFF);
    check_regs;
    foreach (ro_addr[i]) begin
      wr(ro_addr[i], 32'hFFFF_FFFF);
    end
    wr(OFF_STAT, 32'h0001_0000);
    sticky = 1'b0;
    check_regs;
    rd(OFF_CTRL, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    fn_en = 1'b0;
    rd(OFF_FN_PTR, 32'h0000_0000);
    rd(OFF_FN_TBL, 32'h0000_0000);
    rd(OFF_BND_PTR, ptr(OFF_BND_TBL, fn_q.size()));
    rd(12'h300, 32'h0000_0000);
    rd(OFF_BND_TBL, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0001);
    fn_en = 1'b1;
    @(posedge clk_sys);
    tbl_clear <= 1'b1;
    @(posedge clk_sys);
    tbl_clear <= 1'b0;
    agt_q.delete();
    fn_q.delete();
    ld(1'b0, 4'h3, 8'h05, 12'h040);
    ld(1'b1, 4'h0, 8'h00, 12'h000);
    check_regs;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    stop_test;
  end
endmodule : tb_accel_agent_index_tables
